// [rtl/psrt_core.sv]
// Bus command engine for wiper store, restore, idle and tolerance readback
`timescale 1ns/1ps
//
// Contract
// RL1: Address-write plus instruction 110 with no data byte, then stop, copies wiper to store.
// RL2: Address-write plus instruction 101 with no data byte, then stop, loads store into wiper.
// RL3: The master should follow every restore with a no-operation instruction.
// RL4: After restore the memory-read power state holds until instruction 100 returns to idle.
// RL5: Tolerance bytes are read-only at pointer 11110 (sign and integer) and 11111 (fraction).
// RL6: One tolerance byte is read after a pointer write, repeated start, read, no-ack and stop.
// RL7: After an acknowledged first tolerance byte the pointer advances to 11111 for the next.
// RL8: The first tolerance byte carries the sign in its top bit and integer percent below.
// RL9: The second tolerance byte carries the fraction in units of two to the minus eighth.
// RL10: Tolerance bytes are factory fixed, readable at any time and never altered here.
// RL11: Select pins are sampled once after power-up into the bus address, the only one answered.
// RL12: With write protect active a store is acknowledged but the store is left unchanged.
module psrt_core (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Bus pins, open drain data
    input wire logic sclPin,
    input wire logic sdaPin,
    output logic sdaOut,
    output logic sdaOe,
    // Address select straps
    input wire logic addressSelectLow,
    input wire logic addressSelectHigh,
    // Wiper and nonvolatile store
    input wire logic [psrt_pkg::WIPER_W-1:0] wiperSettingRegister,
    input wire logic [psrt_pkg::WIPER_W-1:0] nonvolatileStore,
    input wire logic writeProtect,
    output logic storeStrobe,
    output logic [psrt_pkg::WIPER_W-1:0] storeData,
    output logic restoreStrobe,
    output logic [psrt_pkg::WIPER_W-1:0] restoreData,
    output logic memReadPower,
    // Factory tolerance bytes
    input wire logic [7:0] toleranceSignInteger,
    input wire logic [7:0] toleranceFraction,
    // Status
    output logic [psrt_pkg::DEV_ADDR_W-1:0] deviceAddress,
    output logic addressReady
);
    import psrt_pkg::*;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Bus address from the two select pins
    function automatic logic [DEV_ADDR_W-1:0] addrDecode(input logic selLow,
                                                         input logic selHigh);
        logic [DEV_ADDR_W-1:0] base;
        base = selLow ? DEV_ADDR_HIGH_BASE : DEV_ADDR_LOW_BASE;
        return selHigh ? (base | DEV_ADDR_SEL_HIGH) : base;
    endfunction : addrDecode

    // Byte returned for a read at the current command and pointer
    function automatic logic [7:0] readByte(input logic [CMD_W-1:0] cmdSel,
                                            input logic [PTR_W-1:0] ptrSel,
                                            input logic [WIPER_W-1:0] wiper,
                                            input logic [WIPER_W-1:0] stored,
                                            input logic [7:0] tolSi,
                                            input logic [7:0] tolFr);
        logic [7:0] value;
        value = BYTE_ZERO;
        if (cmdSel == CMD_WIPER) begin
            value = 8'(wiper);
        end else if (cmdSel == CMD_EEPROM) begin
            if (ptrSel == TOL_SIGN_INT_ADDR) begin
                value = tolSi; // see RL5 see RL8
            end else if (ptrSel == TOL_FRACTION_ADDR) begin
                value = tolFr; // see RL5 see RL9
            end else if (ptrSel == STORE_ADDR) begin
                value = 8'(stored);
            end
        end
        return value;
    endfunction : readByte

    // ---------------------------------------------------------------
    // Pin conditioning
    // ---------------------------------------------------------------
    logic scl;
    logic sda;
    logic selLowLvl;
    logic selHighLvl;
    logic sclPrev;
    logic sdaPrev;

    psrt_pin_sync #(.RESET_LEVEL(1'b1)) sclSync (
        .clock(clock), .rst_b(rst_b), .pinIn(sclPin), .level(scl));
    psrt_pin_sync #(.RESET_LEVEL(1'b1)) sdaSync (
        .clock(clock), .rst_b(rst_b), .pinIn(sdaPin), .level(sda));
    psrt_pin_sync #(.RESET_LEVEL(1'b0)) lowSync (
        .clock(clock), .rst_b(rst_b), .pinIn(addressSelectLow), .level(selLowLvl));
    psrt_pin_sync #(.RESET_LEVEL(1'b0)) highSync (
        .clock(clock), .rst_b(rst_b), .pinIn(addressSelectHigh), .level(selHighLvl));

    // Previous levels for edge and condition detection
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end else begin
            sclPrev <= scl;
            sdaPrev <= sda;
        end
    end

    logic sclRise;
    logic sclFall;
    logic startCond;
    logic stopCond;
    assign sclRise = scl & ~sclPrev;
    assign sclFall = ~scl & sclPrev;
    assign startCond = scl & sclPrev & sdaPrev & ~sda;
    assign stopCond = scl & sclPrev & ~sdaPrev & sda;

    // ---------------------------------------------------------------
    // Strap capture
    // ---------------------------------------------------------------
    logic [2:0] strapCnt;

    // Wait for the strap synchronisers to settle, then latch once only
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strapCnt <= '0;
            addressReady <= 1'b0;
            deviceAddress <= '0;
        end else if (!addressReady) begin
            if (strapCnt == STRAP_SETTLE) begin
                addressReady <= 1'b1; // see RL11
                deviceAddress <= addrDecode(selLowLvl, selHighLvl); // see RL11
            end else begin
                strapCnt <= strapCnt + STRAP_STEP;
            end
        end
    end

    // ---------------------------------------------------------------
    // Bus engine
    // ---------------------------------------------------------------
    psrt_state_e state;
    logic [3:0] bitCnt;
    logic [7:0] shiftReg;
    logic [7:0] txByte;
    logic [CMD_W-1:0] cmd;
    logic [PTR_W-1:0] pointer;
    logic readDir;
    logic instrValid;
    logic dataSeen;
    logic byteDone;
    logic [7:0] nextByte;

    assign byteDone = sclFall && (bitCnt == BYTE_BITS);
    // Byte to send next; on a follow-on byte the pointer has already moved
    assign nextByte = readByte(cmd, pointer, wiperSettingRegister, nonvolatileStore,
                               toleranceSignInteger, toleranceFraction); // see RL10
    assign sdaOut = 1'b0; // Open drain: only ever pulls low

    // Frame handling; start and stop override any state so a lost bit resyncs
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
            bitCnt <= '0;
            shiftReg <= '0;
            txByte <= '0;
            cmd <= CMD_WIPER;
            pointer <= '0;
            readDir <= 1'b0;
            instrValid <= 1'b0;
            dataSeen <= 1'b0;
            sdaOe <= 1'b0;
        end else if (stopCond) begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
        end else if (startCond) begin
            // Repeated start keeps the pointer but cancels pending commands
            state <= addressReady ? ST_ADDR : ST_IDLE; // see RL11
            bitCnt <= BIT_ZERO;
            instrValid <= 1'b0;
            dataSeen <= 1'b0;
            sdaOe <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE, ST_WAIT: begin
                    sdaOe <= 1'b0;
                end
                ST_ADDR, ST_INSTR, ST_WDATA: begin
                    if (sclRise) begin
                        shiftReg <= {shiftReg[6:0], sda};
                        bitCnt <= bitCnt + BIT_STEP;
                    end else if (byteDone) begin
                        sdaOe <= 1'b1;
                        if (state == ST_ADDR) begin
                            if (shiftReg[7:1] == deviceAddress) begin
                                readDir <= shiftReg[0]; // see RL11
                                state <= ST_ADDR_ACK;
                            end else begin
                                sdaOe <= 1'b0;
                                state <= ST_WAIT; // see RL11
                            end
                        end else if (state == ST_INSTR) begin
                            cmd <= shiftReg[7:5];
                            pointer <= shiftReg[4:0]; // see RL6
                            instrValid <= 1'b1; // see RL1 see RL2
                            state <= ST_INSTR_ACK;
                        end else begin
                            // Data bytes belong to the write path elsewhere
                            dataSeen <= 1'b1; // see RL1 see RL2
                            state <= ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK, ST_INSTR_ACK, ST_WDATA_ACK: begin
                    if (sclFall) begin
                        bitCnt <= BIT_ZERO;
                        if (state == ST_ADDR_ACK && readDir) begin
                            txByte <= nextByte; // see RL10
                            sdaOe <= ~nextByte[7];
                            state <= ST_RDATA; // see RL6
                        end else begin
                            sdaOe <= 1'b0;
                            state <= (state == ST_ADDR_ACK) ? ST_INSTR : ST_WDATA;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt <= bitCnt + BIT_STEP;
                    end else if (byteDone) begin
                        sdaOe <= 1'b0;
                        state <= ST_RACK;
                    end else if (sclFall) begin
                        sdaOe <= ~txByte[3'(BYTE_BITS - BIT_STEP - bitCnt)];
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        if (sda) begin
                            state <= ST_WAIT; // see RL6
                        end else begin
                            pointer <= pointer + PTR_STEP; // see RL7
                        end
                    end else if (sclFall) begin
                        bitCnt <= BIT_ZERO;
                        txByte <= nextByte; // see RL7
                        sdaOe <= ~nextByte[7];
                        state <= ST_RDATA;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Command execution
    // ---------------------------------------------------------------
    // Store and restore fire at stop only when no data byte followed the instruction
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            storeStrobe <= 1'b0;
            storeData <= '0;
            restoreStrobe <= 1'b0;
            restoreData <= '0;
            memReadPower <= 1'b0;
        end else begin
            storeStrobe <= 1'b0;
            restoreStrobe <= 1'b0;
            if (stopCond && instrValid && !dataSeen) begin
                if (cmd == CMD_STORE && !writeProtect) begin
                    storeStrobe <= 1'b1; // see RL1 see RL12
                    storeData <= wiperSettingRegister; // see RL1
                end else if (cmd == CMD_RESTORE) begin
                    restoreStrobe <= 1'b1; // see RL2
                    restoreData <= nonvolatileStore; // see RL2
                    memReadPower <= 1'b1; // see RL4
                end
            end
            // Higher power state is left only on an explicit no-operation
            if (state == ST_INSTR && byteDone && shiftReg[7:5] == CMD_NOP) begin
                memReadPower <= 1'b0; // see RL4 see RL3
            end
        end
    end

endmodule : psrt_core

// [rtl/psrt_pin_sync.sv]
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module psrt_pin_sync #(
    parameter logic RESET_LEVEL = 1'b1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Pin and clean level
    input wire logic pinIn,
    output logic level
);

    logic stage1;
    logic stage2;
    logic stage3;

    // Chain; stage1 feeds only stage2 to keep metastability contained
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= RESET_LEVEL;
            stage2 <= RESET_LEVEL;
            stage3 <= RESET_LEVEL;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A change counts only once the two settled stages agree
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            level <= RESET_LEVEL;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end

endmodule : psrt_pin_sync

// [rtl/psrt_pkg.sv]
// Shared constants for the potentiometer store, restore and tolerance command block
package psrt_pkg;

    // ---------------------------------------------------------------
    // Widths
    // ---------------------------------------------------------------
    localparam int WIPER_W = 6;
    localparam int PTR_W = 5;
    localparam int CMD_W = 3;
    localparam int DEV_ADDR_W = 7;

    // ---------------------------------------------------------------
    // Instruction byte command codes (top three bits)
    // ---------------------------------------------------------------
    localparam logic [CMD_W-1:0] CMD_WIPER = 3'h0;
    localparam logic [CMD_W-1:0] CMD_EEPROM = 3'h1;
    localparam logic [CMD_W-1:0] CMD_PROTECT = 3'h2;
    localparam logic [CMD_W-1:0] CMD_NOP = 3'h4;
    localparam logic [CMD_W-1:0] CMD_RESTORE = 3'h5;
    localparam logic [CMD_W-1:0] CMD_STORE = 3'h6;

    // ---------------------------------------------------------------
    // Memory pointer addresses
    // ---------------------------------------------------------------
    localparam logic [PTR_W-1:0] STORE_ADDR = 5'h00;
    localparam logic [PTR_W-1:0] TOL_SIGN_INT_ADDR = 5'h1e;
    localparam logic [PTR_W-1:0] TOL_FRACTION_ADDR = 5'h1f;
    localparam logic [PTR_W-1:0] PTR_STEP = 5'h01;

    // ---------------------------------------------------------------
    // Bus address decode from the two select pins
    // ---------------------------------------------------------------
    localparam logic [DEV_ADDR_W-1:0] DEV_ADDR_LOW_BASE = 7'h18;
    localparam logic [DEV_ADDR_W-1:0] DEV_ADDR_HIGH_BASE = 7'h4c;
    localparam logic [DEV_ADDR_W-1:0] DEV_ADDR_SEL_HIGH = 7'h02;

    // ---------------------------------------------------------------
    // Bit counting and reset settling
    // ---------------------------------------------------------------
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [3:0] BIT_STEP = 4'h1;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [2:0] STRAP_SETTLE = 3'h5;
    localparam logic [2:0] STRAP_STEP = 3'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ---------------------------------------------------------------
    // Bus engine states
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h2,
        ST_INSTR = 4'h3,
        ST_INSTR_ACK = 4'h4,
        ST_WDATA = 4'h5,
        ST_WDATA_ACK = 4'h6,
        ST_RDATA = 4'h7,
        ST_RACK = 4'h8,
        ST_WAIT = 4'h9
    } psrt_state_e;

endpackage : psrt_pkg

// [tb/psrt_core_asserts.sv]
// Checker for the store, restore and tolerance command block
`timescale 1ns/1ps
module psrt_core_asserts (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Bus pins
    input wire logic sclPin,
    input wire logic sdaPin,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Straps
    input wire logic addressSelectLow,
    input wire logic addressSelectHigh,
    // Wiper and store
    input wire logic [psrt_pkg::WIPER_W-1:0] wiperSettingRegister,
    input wire logic [psrt_pkg::WIPER_W-1:0] nonvolatileStore,
    input wire logic writeProtect,
    input wire logic storeStrobe,
    input wire logic [psrt_pkg::WIPER_W-1:0] storeData,
    input wire logic restoreStrobe,
    input wire logic [psrt_pkg::WIPER_W-1:0] restoreData,
    input wire logic memReadPower,
    // Tolerance and status
    input wire logic [7:0] toleranceSignInteger,
    input wire logic [7:0] toleranceFraction,
    input wire logic [psrt_pkg::DEV_ADDR_W-1:0] deviceAddress,
    input wire logic addressReady
);
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    // One clock domain, so clocking and reset are given once
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    property p_storePulse; storeStrobe |=> !storeStrobe; endproperty
    a_storePulse: assert property (p_storePulse)
        else $error("store strobe longer than one cycle");
    property p_storeData; storeStrobe |-> storeData == $past(wiperSettingRegister); endproperty
    a_storeData: assert property (p_storeData)
        else $error("stored value is not the wiper");
    property p_restoreData; restoreStrobe |-> restoreData == $past(nonvolatileStore); endproperty
    a_restoreData: assert property (p_restoreData)
        else $error("restored value is not the store");
    property p_restorePulse; restoreStrobe |=> !restoreStrobe; endproperty
    a_restorePulse: assert property (p_restorePulse)
        else $error("restore strobe longer than one cycle");
    property p_readPower; restoreStrobe |-> ##[0:1] memReadPower; endproperty
    a_readPower: assert property (p_readPower)
        else $error("read power state not entered on restore");
    // A NOP drops the power state in the same cycle that it starts acking its instruction
    property p_nopAck; $fell(memReadPower) |-> ##[0:10] sdaOe; endproperty
    a_nopAck: assert property (p_nopAck)
        else $error("read power state left outside an instruction");
    property p_protect; storeStrobe |-> !$past(writeProtect); endproperty
    a_protect: assert property (p_protect)
        else $error("store written while protected");
    property p_addrDecode;
        $rose(addressReady) |-> deviceAddress == ((addressSelectLow ? 7'h4c : 7'h18)
            | (addressSelectHigh ? 7'h02 : 7'h00));
    endproperty
    a_addrDecode: assert property (p_addrDecode)
        else $error("bus address decode wrong");
    property p_addrHold; addressReady && $past(addressReady) |-> $stable(deviceAddress); endproperty
    a_addrHold: assert property (p_addrHold)
        else $error("bus address changed after capture");
    c_store: cover property (storeStrobe);
    c_restore: cover property (restoreStrobe);
    c_nop: cover property ($fell(memReadPower));
endmodule : psrt_core_asserts
bind psrt_core psrt_core_asserts chk (.clock(clock), .rst_b(rst_b), .sclPin(sclPin),
    .sdaPin(sdaPin), .sdaOut(sdaOut), .sdaOe(sdaOe), .addressSelectLow(addressSelectLow),
    .addressSelectHigh(addressSelectHigh), .wiperSettingRegister(wiperSettingRegister),
    .nonvolatileStore(nonvolatileStore), .writeProtect(writeProtect),
    .storeStrobe(storeStrobe), .storeData(storeData), .restoreStrobe(restoreStrobe),
    .restoreData(restoreData), .memReadPower(memReadPower),
    .toleranceSignInteger(toleranceSignInteger), .toleranceFraction(toleranceFraction),
    .deviceAddress(deviceAddress), .addressReady(addressReady));

// [tb/psrt_core_bench.sv]
// Testbench for the store, restore and tolerance command block
`timescale 1ns/1ps
module psrt_core_bench;
    import psrt_pkg::*;
    // ---------------------------------------------------------------
    // Signals, clock and instances
    // ---------------------------------------------------------------
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic sclPin, sdaPin, sdaDrive, sdaOut, sdaOe, a;
    logic addressSelectLow = 1'b1;
    logic addressSelectHigh = 1'b0;
    logic [WIPER_W-1:0] wiperSettingRegister = 6'h00;
    logic [WIPER_W-1:0] nonvolatileStore = 6'h00;
    logic [WIPER_W-1:0] storeData, restoreData, storeSeen, restoreSeen;
    logic writeProtect = 1'b0;
    logic storeStrobe, restoreStrobe, memReadPower, addressReady;
    logic [7:0] toleranceSignInteger = 8'h9c;
    logic [7:0] toleranceFraction = 8'h0f;
    logic [DEV_ADDR_W-1:0] deviceAddress;
    int storeCnt = 0;
    int restoreCnt = 0;
    int n_fail = 0;
    int checks = 0;
    always #10 clock = ~clock;
    // Pull-up bus: low when either side pulls
    assign sdaPin = sdaDrive & ~(sdaOe & ~sdaOut);
    psrt_i2c_master mst (.clock(clock), .sdaLine(sdaPin), .sclPin(sclPin), .sdaDrive(sdaDrive));
    psrt_core uut (.clock(clock), .rst_b(rst_b), .sclPin(sclPin), .sdaPin(sdaPin),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addressSelectLow(addressSelectLow),
        .addressSelectHigh(addressSelectHigh), .wiperSettingRegister(wiperSettingRegister),
        .nonvolatileStore(nonvolatileStore), .writeProtect(writeProtect),
        .storeStrobe(storeStrobe), .storeData(storeData), .restoreStrobe(restoreStrobe),
        .restoreData(restoreData), .memReadPower(memReadPower),
        .toleranceSignInteger(toleranceSignInteger), .toleranceFraction(toleranceFraction),
        .deviceAddress(deviceAddress), .addressReady(addressReady));
    // Strobes are one cycle wide, so they are caught on every edge
    always @(posedge clock) begin
        if (storeStrobe === 1'b1) begin
            storeCnt++;
            storeSeen = storeData;
        end
        if (restoreStrobe === 1'b1) begin
            restoreCnt++;
            restoreSeen = restoreData;
        end
    end
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : checkByte
    task automatic checkFlag(input logic got, input logic exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
        end
    endtask : checkFlag
    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // Address plus one instruction, no data byte, then stop
    task automatic sendCmd(input logic [7:0] instr);
        mst.start();
        mst.writeByte(8'h98, a);
        checkFlag(a, 1'b1, "address ack");
        mst.writeByte(instr, a);
        checkFlag(a, 1'b1, "instruction ack");
        mst.stop();
        mst.tick(10);
    endtask : sendCmd
    // Pointer write, repeated start, then one or two bytes read back
    task automatic tolRead(input logic [4:0] ptr, input logic two, input logic [15:0] exp);
        logic [7:0] b;
        mst.start();
        mst.writeByte(8'h98, a);
        checkFlag(a, 1'b1, "address ack");
        mst.writeByte({CMD_EEPROM, ptr}, a);
        checkFlag(a, 1'b1, "pointer ack");
        mst.start(); // Repeated start, the bus is never released
        mst.writeByte(8'h99, a);
        checkFlag(a, 1'b1, "read address ack");
        mst.readByte(two, b);
        checkByte(b, exp[15:8], "first byte");
        if (two) begin
            mst.readByte(1'b0, b);
            checkByte(b, exp[7:0], "second byte");
        end
        mst.stop();
        mst.tick(10);
        $display("test tolerance %h done", ptr);
    endtask : tolRead
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    // A hang is cut short well beyond the expected run of some 110 us
    initial begin
        #1000000;
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        give_verdict();
    end
    initial begin
        mst.tick(5);
        rst_b <= 1'b1;
        wiperSettingRegister <= 6'h2a;
        nonvolatileStore <= 6'h15;
        mst.tick(20);
        checkFlag(addressReady, 1'b1, "address ready");
        checkByte({1'b0, deviceAddress}, 8'h4c, "address");
        mst.start();
        mst.writeByte(8'h30, a);
        mst.stop();
        checkFlag(a, 1'b0, "foreign address");
        $display("test address done");
        sendCmd({CMD_STORE, 5'h00});
        checkByte(8'(storeCnt), 8'h01, "store count");
        checkByte({2'b00, storeSeen}, 8'h2a, "store data");
        writeProtect <= 1'b1;
        sendCmd({CMD_STORE, 5'h00});
        checkByte(8'(storeCnt), 8'h01, "protected store");
        writeProtect <= 1'b0;
        $display("test store done");
        sendCmd({CMD_RESTORE, 5'h00});
        checkByte(8'(restoreCnt), 8'h01, "restore count");
        checkByte({2'b00, restoreSeen}, 8'h15, "restore data");
        checkFlag(memReadPower, 1'b1, "read power on");
        sendCmd({CMD_NOP, 5'h00});
        checkFlag(memReadPower, 1'b0, "read power off");
        $display("test restore done");
        tolRead(5'h1e, 1'b0, 16'h9c00);
        tolRead(5'h1f, 1'b0, 16'h0f00);
        tolRead(5'h1e, 1'b1, 16'h9c0f);
        tolRead(5'h00, 1'b0, 16'h1500);
        give_verdict();
    end
endmodule : psrt_core_bench

// [tb/psrt_i2c_master.sv]
// Bus master model that drives the serial clock and data pins
`timescale 1ns/1ps
module psrt_i2c_master #(
    parameter int HALF = 10
) (
    // Clock
    input wire logic clock,
    // Bus pins, data is wired-and with a pull-up
    input wire logic sdaLine,
    output logic sclPin,
    output logic sdaDrive
);
    // ---------------------------------------------------------------
    // Bit and byte tasks
    // ---------------------------------------------------------------
    // Idle bus rests high; a released data line shows the pull-up
    initial begin
        sclPin = 1'b1;
        sdaDrive = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick
    // Half phases of ten clocks leave room for the pin filter
    task automatic phase(input logic s, input logic d);
        sclPin <= s;
        sdaDrive <= d;
        tick(HALF);
    endtask : phase
    // Also serves as repeated start from a low clock
    task automatic start();
        phase(1'b0, 1'b1);
        phase(1'b1, 1'b1);
        phase(1'b1, 1'b0);
        phase(1'b0, 1'b0);
    endtask : start
    task automatic stop();
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask : stop
    // Sample mid high phase, where the device's bit stands still
    task automatic recvBit(output logic b);
        phase(1'b0, 1'b1);
        sclPin <= 1'b1;
        tick(HALF / 2);
        b = sdaLine;
        tick(HALF / 2);
    endtask : recvBit
    task automatic writeByte(input logic [7:0] b, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            phase(1'b0, b[i]);
            phase(1'b1, b[i]);
        end
        recvBit(a);
        ack = ~a;
    endtask : writeByte
    // Acknowledge asks for the next byte, no-acknowledge ends the read
    task automatic readByte(input logic mack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            recvBit(b[i]);
        end
        phase(1'b0, ~mack);
        phase(1'b1, ~mack);
    endtask : readByte
endmodule : psrt_i2c_master
